// file: design/cep_pkg.sv
// Constants and carrier types for the CAN error counter, interrupt and prescaler block.
// Assumes an AXI4-Lite master on the register side and a protocol engine on the same clock.
// Function
// - Receive counter readable, seven bits 14:8
// - Bit 15 high when receive count reaches 128
// - Receive field meaningless while receive error passive
// - Transmit counter readable, eight bits, 0 to 255
// - Transmit field meaningless while bus-off
// - Counter register read-only, offset 054, resets 0000
// - Six enable bits gate pending flags onto interrupt
// - Enable write: set bit 8+i, clear bit i
// - Six pending flags, bits 15:6 read zero
// - Pending bits: wake, arbitration, protocol, state, rx, tx
// - Wake flag only from bus activity wakeup
// - Writing one clears pending flag, zero keeps
// - Quantum clock is module clock over n+1
// - Reset: enable, pending zero, prescaler FF
// - Bus-off when transmit count reaches 256
package cep_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          CEP_AW        = 12;
  localparam logic [11:0] CEP_IDX_ERC   = 12'h054;
  localparam logic [11:0] CEP_IDX_IE    = 12'h056;
  localparam logic [11:0] CEP_IDX_PEND  = 12'h058;
  localparam logic [11:0] CEP_IDX_PRESC = 12'h05A;
  localparam logic [11:0] CEP_ADDR_ERC   = {CEP_IDX_ERC[9:0], 2'h0};
  localparam logic [11:0] CEP_ADDR_IE    = {CEP_IDX_IE[9:0], 2'h0};
  localparam logic [11:0] CEP_ADDR_PEND  = {CEP_IDX_PEND[9:0], 2'h0};
  localparam logic [11:0] CEP_ADDR_PRESC = {CEP_IDX_PRESC[9:0], 2'h0};

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          CEP_NIRQ        = 6;
  localparam int          CEP_SET_LSB     = 8;
  localparam int          CEP_PASSIVE_BIT = 15;
  localparam logic [7:0]  CEP_RX_PASSIVE  = 8'h80;
  localparam logic [8:0]  CEP_TX_BUSOFF   = 9'h100;
  localparam logic [15:0] CEP_ERC_RST     = 16'h0000;
  localparam logic [5:0]  CEP_IE_RST      = 6'h00;
  localparam logic [5:0]  CEP_PEND_RST    = 6'h00;
  localparam logic [7:0]  CEP_PRESC_RST   = 8'hFF;
  localparam logic [1:0]  CEP_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  CEP_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wake_bus;
    logic arb_lost;
    logic proto_err;
    logic err_state;
    logic rx_done;
    logic tx_done;
  } cep_evt_t;

  typedef struct packed {
    logic [8:0] tx;
    logic [7:0] rx;
  } cep_cnt_t;

  typedef enum logic [0:0] {
    CEP_RD_IDLE = 1'b0,
    CEP_RD_RESP = 1'b1
  } cep_rd_state_t;

endpackage

// file: design/cep_top.sv
// Error counter view, interrupt enable and pending registers, quantum clock prescaler.
// Assumes the protocol engine drives counters and event pulses on aclk.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module cep_top (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [11:0]              awaddr,
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  input  wire logic [11:0]              araddr,
  input  wire logic                     arvalid,
  output logic                          arready,
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  wire logic                     rready,
  input  wire logic                     init_mode,
  input  wire cep_pkg::cep_cnt_t        err_cnt,
  input  wire cep_pkg::cep_evt_t        evt,
  output logic                          irq,
  output logic                          tq_enable,
  output logic                          bus_off_flag,
  output logic                          rx_passive_flag
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [11:0]                  aw_addr;
  logic                         aw_full;
  logic [31:0]                  w_data;
  logic [3:0]                   w_strb;
  logic                         w_full;
  logic                         do_write;
  logic [15:0]                  wd;
  logic [15:0]                  erc;
  logic [5:0]                   ie;
  logic [5:0]                   pend;
  logic [7:0]                   presc;
  logic [7:0]                   div_cnt;
  logic [5:0]                   next_ie;
  logic [5:0]                   next_pend;
  logic [5:0]                   evt_bits;
  logic                         wr_ie;
  logic                         wr_pend;
  logic                         wr_presc;
  logic [31:0]                  next_rdata;
  logic [1:0]                   next_rresp;
  logic [1:0]                   next_bresp;
  cep_pkg::cep_rd_state_t       rd_state;

  assign evt_bits = evt;

  // ----------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------
  assign awready  = !aw_full;
  assign wready   = !w_full;
  assign do_write = aw_full && w_full && !bvalid;
  assign wd       = {w_strb[1] ? w_data[15:8] : 8'h00, w_strb[0] ? w_data[7:0] : 8'h00};
  assign wr_ie    = do_write && (aw_addr == cep_pkg::CEP_ADDR_IE);
  assign wr_pend  = do_write && (aw_addr == cep_pkg::CEP_ADDR_PEND);
  assign wr_presc = do_write && (aw_addr == cep_pkg::CEP_ADDR_PRESC) && w_strb[0]
                    && init_mode;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
    end else if (awvalid && awready) begin
      aw_full <= 1'b1;
      aw_addr <= awaddr;
    end else if (do_write) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (wvalid && wready) begin
      w_full <= 1'b1;
      w_data <= wdata;
      w_strb <= wstrb;
    end else if (do_write) begin
      w_full <= 1'b0;
    end
  end

  always_comb begin
    case (aw_addr)
      cep_pkg::CEP_ADDR_ERC,
      cep_pkg::CEP_ADDR_IE,
      cep_pkg::CEP_ADDR_PEND,
      cep_pkg::CEP_ADDR_PRESC: begin
        next_bresp = cep_pkg::CEP_RESP_OKAY;
      end
      default: begin
        next_bresp = cep_pkg::CEP_RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= cep_pkg::CEP_RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= next_bresp;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign arready = (rd_state == cep_pkg::CEP_RD_IDLE);
  assign rvalid  = (rd_state == cep_pkg::CEP_RD_RESP);

  always_comb begin
    next_rdata = '0;
    next_rresp = cep_pkg::CEP_RESP_OKAY;
    case (araddr)
      cep_pkg::CEP_ADDR_ERC: begin
        next_rdata[15:0] = erc;
      end
      cep_pkg::CEP_ADDR_IE: begin
        next_rdata[5:0] = ie;
      end
      cep_pkg::CEP_ADDR_PEND: begin
        next_rdata[5:0] = pend;
      end
      cep_pkg::CEP_ADDR_PRESC: begin
        next_rdata[7:0] = presc;
      end
      default: begin
        next_rresp = cep_pkg::CEP_RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= cep_pkg::CEP_RD_IDLE;
      rdata    <= '0;
      rresp    <= cep_pkg::CEP_RESP_OKAY;
    end else begin
      case (rd_state)
        cep_pkg::CEP_RD_IDLE: begin
          if (arvalid) begin
            rd_state <= cep_pkg::CEP_RD_RESP;
            rdata    <= next_rdata;
            rresp    <= next_rresp;
          end
        end
        cep_pkg::CEP_RD_RESP: begin
          if (rready) begin
            rd_state <= cep_pkg::CEP_RD_IDLE;
          end
        end
        default: begin
          rd_state <= cep_pkg::CEP_RD_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Error counter view
  // ----------------------------------------------------------------
  // The receive field shows the low bits even when passive and is then meaningless.
  // The transmit field shows the low bits even when bus-off and is then meaningless.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erc             <= cep_pkg::CEP_ERC_RST;
      bus_off_flag    <= 1'b0;
      rx_passive_flag <= 1'b0;
    end else begin
      erc[cep_pkg::CEP_PASSIVE_BIT] <= (err_cnt.rx >= cep_pkg::CEP_RX_PASSIVE);
      erc[14:8]       <= err_cnt.rx[6:0];
      erc[7:0]        <= err_cnt.tx[7:0];
      bus_off_flag    <= (err_cnt.tx >= cep_pkg::CEP_TX_BUSOFF);
      rx_passive_flag <= (err_cnt.rx >= cep_pkg::CEP_RX_PASSIVE);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt enable and pending
  // ----------------------------------------------------------------
  always_comb begin
    next_ie = ie;
    if (wr_ie) begin
      next_ie = (ie | (wd[13:8] & ~wd[5:0])) & ~(wd[5:0] & ~wd[13:8]);
    end
  end

  always_comb begin
    next_pend = pend;
    if (wr_pend) begin
      next_pend = pend & ~wd[5:0];
    end
    next_pend = next_pend | evt_bits;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ie   <= cep_pkg::CEP_IE_RST;
      pend <= cep_pkg::CEP_PEND_RST;
      irq  <= 1'b0;
    end else begin
      ie   <= next_ie;
      pend <= next_pend;
      irq  <= |(pend & ie);
    end
  end

  // ----------------------------------------------------------------
  // Quantum clock prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc     <= cep_pkg::CEP_PRESC_RST;
      div_cnt   <= cep_pkg::CEP_PRESC_RST;
      tq_enable <= 1'b0;
    end else if (wr_presc) begin
      presc     <= wd[7:0];
      div_cnt   <= wd[7:0];
      tq_enable <= 1'b0;
    end else begin
      tq_enable <= (div_cnt == 8'h00);
      div_cnt   <= (div_cnt == 8'h00) ? presc : div_cnt - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [8:0] gap;
  logic       gap_ok;

  always_ff @(posedge aclk) begin
    if (!aresetn || wr_presc) begin
      gap    <= '0;
      gap_ok <= 1'b0;
    end else if (tq_enable) begin
      gap    <= 9'h001;
      gap_ok <= 1'b1;
    end else begin
      gap    <= gap + 9'h001;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence write_pair_s;
    aw_full && w_full && !bvalid;
  endsequence

  sequence read_take_s;
    arvalid && arready;
  endsequence

  sequence ie_set0_s;
    wr_ie && wd[cep_pkg::CEP_SET_LSB] && !wd[0];
  endsequence

  sequence ie_clr0_s;
    wr_ie && !wd[cep_pkg::CEP_SET_LSB] && wd[0];
  endsequence

  sequence pend_clr0_s;
    wr_pend && wd[0] && !evt_bits[0];
  endsequence

  rx_passive_view_a: assert property (
    erc[cep_pkg::CEP_PASSIVE_BIT] == ($past(err_cnt.rx) >= cep_pkg::CEP_RX_PASSIVE))
    else $error("passive bit does not follow receive count");

  rx_field_view_a: assert property (
    erc[14:8] == $past(err_cnt.rx[6:0]) && erc[7:0] == $past(err_cnt.tx[7:0]))
    else $error("counter fields do not follow counters");

  bus_off_view_a: assert property (
    bus_off_flag == ($past(err_cnt.tx) >= cep_pkg::CEP_TX_BUSOFF))
    else $error("bus-off flag wrong");

  ie_set_bit_a: assert property (
    ie_set0_s |=> ie[0])
    else $error("enable set request lost");

  irq_gate_a: assert property (
    |(pend & ie) |=> irq)
    else $error("interrupt output wrong");

  irq_low_a: assert property (
    !(|(pend & ie)) |=> !irq)
    else $error("interrupt raised with nothing enabled");

  pend_set_a: assert property (
    |evt_bits |=> (pend & $past(evt_bits)) == $past(evt_bits))
    else $error("event lost in pending flags");

  pend_hold_a: assert property (
    !wr_pend |=> (pend & $past(pend)) == $past(pend))
    else $error("pending flag fell without a clearing write");

  presc_period_a: assert property (
    tq_enable && gap_ok |-> gap == ({1'b0, presc} + 9'h001))
    else $error("quantum period is not prescaler plus one");

  write_resp_a: assert property (
    write_pair_s |=> bvalid)
    else $error("write response missing");

  read_resp_a: assert property (
    read_take_s |=> rvalid && (rdata[31:16] == 16'h0000))
    else $error("read response missing");

  ie_clear_bit_a: assert property (
    ie_clr0_s |=> !ie[0])
    else $error("enable clear request lost");

  ie_hold_a: assert property (
    !wr_ie |=> ie == $past(ie))
    else $error("enable bits changed without a write");

  pend_clear_a: assert property (
    pend_clr0_s |=> !pend[0])
    else $error("pending flag not cleared by write");

  wake_only_a: assert property (
    !evt.wake_bus |=> !pend[5] || $past(pend[5]))
    else $error("wake flag set without wake event");

  presc_locked_a: assert property (
    !init_mode |=> presc == $past(presc))
    else $error("prescaler changed outside initialization mode");

  tq_pulse_a: assert property (
    tq_enable && presc != 8'h00 |=> !tq_enable)
    else $error("quantum enable wider than one cycle");

  tq_reload_a: assert property (
    wr_presc |=> !tq_enable)
    else $error("quantum enable not restarted by prescaler write");

  passive_flag_a: assert property (
    rx_passive_flag == ($past(err_cnt.rx) >= cep_pkg::CEP_RX_PASSIVE))
    else $error("passive flag does not follow receive count");

  bresp_hold_a: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before it was taken");

  rdata_hold_a: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read response dropped before it was taken");

  pend_read_a: assert property (
    read_take_s ##0 (araddr == cep_pkg::CEP_ADDR_PEND) |=>
      rdata[5:0] == $past(pend) && rdata[15:6] == 10'h000)
    else $error("pending read shows wrong bits");

  reset_vals_a: assert property (
    @(posedge aclk) disable iff (1'b0)
    !aresetn |=> (ie == 6'h00 && pend == 6'h00 && presc == 8'hFF && erc == 16'h0000))
    else $error("reset values wrong");

endmodule

// file: verif/cep_engine_model.sv
// Protocol engine stand-in that drives the error counters and the event pulses.
// Assumes the bench requests counter values and one-cycle event pulses on aclk.
`timescale 1ns/1ps
module cep_engine_model (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire cep_pkg::cep_cnt_t cnt_next,
  input  wire cep_pkg::cep_evt_t evt_req,
  output cep_pkg::cep_cnt_t      err_cnt,
  output cep_pkg::cep_evt_t      evt
);
  // ----------------------------------------------------------------
  // Counters and events
  // ----------------------------------------------------------------
  // Counters follow the requested protocol count, full nine and eight bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_cnt <= '0;
    end else begin
      err_cnt <= cnt_next;
    end
  end

  // The wake event, like every other event, follows the bench request one cycle later.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt <= '0;
    end else begin
      evt <= evt_req;
    end
  end
endmodule

// file: verif/can_err_irq_prescaler_tb.sv
// Self-checking bench for the error counter, interrupt and prescaler block.
// Assumes cep_pkg, cep_top and cep_engine_model are compiled before it.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module can_err_irq_prescaler_tb;
  logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, init_mode;
  logic              awready, wready, bvalid, arready, rvalid, irq, tq_enable;
  logic              bus_off_flag, rx_passive_flag;
  logic [11:0]       awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic [33:0]       exp_q[$];
  logic [33:0]       exp_e;
  logic [5:0]        pend;
  cep_pkg::cep_cnt_t err_cnt, cnt_next, c;
  cep_pkg::cep_evt_t evt, evt_req;
  cep_pkg::cep_cnt_t tbl[4] = '{{9'h0FF, 8'h7F}, {9'h100, 8'h80}, {9'h1FF, 8'hFF}, 17'h0};
  int                fail_count, samples_checked;

  cep_top cep_top_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .init_mode, .err_cnt, .evt, .irq, .tq_enable,
    .bus_off_flag, .rx_passive_flag);
  cep_engine_model cep_engine_model_inst (.aclk, .aresetn, .cnt_next, .evt_req, .err_cnt,
    .evt);

  // ----------------------------------------------------------------
  // Bus tasks and helpers
  // ----------------------------------------------------------------
  function automatic logic [33:0] ok(input logic [15:0] v);
    return {cep_pkg::CEP_RESP_OKAY, 16'h0, v};
  endfunction

  function automatic logic [33:0] erc(input cep_pkg::cep_cnt_t v);
    return ok({v.rx >= 8'h80, v.rx[6:0], v.tx[7:0]});
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r,
                    input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bready && bvalid) begin
        bready <= 1'h0;
        `CHK(bresp, r)
      end
    end while (!(bready && bvalid) && n < 100);
    `CHK(n < 100, 1'b1)
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    int n;
    n = 0;
    exp_q.push_back(e);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'h0;
      if (rready && rvalid) rready <= 1'h0;
    end while (!(rready && rvalid) && n < 100);
    `CHK(n < 100, 1'b1)
    @(posedge aclk);
  endtask

  task automatic tq_period(input int want);
    int n;
    n = 0;
    do @(posedge aclk); while (tq_enable !== 1'h1 && n++ < 600);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (tq_enable !== 1'h1 && n < 600);
    `CHK(n, want)
  endtask

  task automatic give_verdict;
    if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge aclk) begin
    if (rvalid === 1'h1 && rready === 1'h1 && exp_q.size() > 0) begin
      exp_e = exp_q.pop_front();
      `CHK({rresp, rdata}, exp_e)
    end
  end

  initial begin
    aclk = 1'h0;
    forever #2.5 aclk = ~aclk;
  end

  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, init_mode} = '0;
    {awaddr, araddr, wdata, wstrb, cnt_next, evt_req, pend} = '0;
    void'($urandom(32'hDB72));
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(cep_pkg::CEP_ADDR_ERC, ok(16'h0000));
    rd(cep_pkg::CEP_ADDR_IE, ok(16'h0000));
    rd(cep_pkg::CEP_ADDR_PEND, ok(16'h0000));
    rd(cep_pkg::CEP_ADDR_PRESC, ok(16'h00FF));
    tq_period(256);
    rd(12'h7F0, {cep_pkg::CEP_RESP_SLVERR, 32'h0});
    wr(12'h7F0, 32'hFFFF, cep_pkg::CEP_RESP_SLVERR);
    for (int i = 0; i < 12; i++) begin
      c = (i < 4) ? tbl[i] : 17'($urandom());
      cnt_next <= c;
      repeat (3) @(posedge aclk);
      `CHK(bus_off_flag, c.tx >= 9'h100)
      `CHK(rx_passive_flag, c.rx >= 8'h80)
      rd(cep_pkg::CEP_ADDR_ERC, erc(c));
    end
    wr(cep_pkg::CEP_ADDR_ERC, 32'hFFFF, cep_pkg::CEP_RESP_OKAY);
    rd(cep_pkg::CEP_ADDR_ERC, erc(c));
    wr(cep_pkg::CEP_ADDR_IE, 32'h3F00, cep_pkg::CEP_RESP_OKAY);
    rd(cep_pkg::CEP_ADDR_IE, ok(16'h003F));
    wr(cep_pkg::CEP_ADDR_IE, 32'h0303, cep_pkg::CEP_RESP_OKAY);
    rd(cep_pkg::CEP_ADDR_IE, ok(16'h003F));
    wr(cep_pkg::CEP_ADDR_IE, 32'h0003, cep_pkg::CEP_RESP_OKAY);
    rd(cep_pkg::CEP_ADDR_IE, ok(16'h003C));
    wr(cep_pkg::CEP_ADDR_IE, 32'h003F, cep_pkg::CEP_RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      evt_req <= cep_pkg::cep_evt_t'(6'h01 << i);
      @(posedge aclk);
      evt_req <= '0;
      repeat (3) @(posedge aclk);
      pend = pend | (6'h01 << i);
      rd(cep_pkg::CEP_ADDR_PEND, ok({10'h0, pend}));
      `CHK(irq, 1'h0)
    end
    wr(cep_pkg::CEP_ADDR_IE, 32'h3F00, cep_pkg::CEP_RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'h1)
    wr(cep_pkg::CEP_ADDR_PEND, 32'hFF05, cep_pkg::CEP_RESP_OKAY);
    rd(cep_pkg::CEP_ADDR_PEND, ok(16'h003A));
    wr(cep_pkg::CEP_ADDR_IE, 32'h003B, cep_pkg::CEP_RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'h0)
    wr(cep_pkg::CEP_ADDR_IE, 32'h0200, cep_pkg::CEP_RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'h1)
    wr(cep_pkg::CEP_ADDR_PEND, 32'h003F, cep_pkg::CEP_RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'h0)
    wr(cep_pkg::CEP_ADDR_PRESC, 32'h03, cep_pkg::CEP_RESP_OKAY);
    rd(cep_pkg::CEP_ADDR_PRESC, ok(16'h00FF));
    init_mode <= 1'h1;
    @(posedge aclk);
    wr(cep_pkg::CEP_ADDR_PRESC, 32'h03, cep_pkg::CEP_RESP_OKAY);
    rd(cep_pkg::CEP_ADDR_PRESC, ok(16'h0003));
    wr(cep_pkg::CEP_ADDR_PRESC, 32'h07, cep_pkg::CEP_RESP_OKAY, 4'hE);
    rd(cep_pkg::CEP_ADDR_PRESC, ok(16'h0003));
    tq_period(4);
    wr(cep_pkg::CEP_ADDR_PRESC, 32'h00, cep_pkg::CEP_RESP_OKAY);
    tq_period(1);
    give_verdict();
  end
endmodule
